// [hdl/vcd_pkg.sv]
// Package with constants, types and notes for the video capture RISC DMA engine.
// Functional notes
// [R1] The engine is a small processor that fetches and runs a program held in host memory.
// [R2] An audio copy of the engine behaves the same but has no planar instructions, chosen by a parameter.
// Here PLANAR_EN gates only the planar tag; planar opcodes halt as unknown in both settings.
// [R3] Every write instruction carries its own target address, so each line may land anywhere.
// [R4] Several targets per frame are served by successive write instructions with distinct addresses.
// [R5] The program start address comes from a device register and seeds the fetch address.
// [R6] With a start address loaded the engine fetches an instruction before any data transfer.
// [R7] The engine decodes and runs write, skip, synchronize and jump instructions.
// [R8] Pixel data goes from the FIFO to the bus-master port with a write request to the target.
// [R9] The engine drains the FIFO and, on overflow, discards data until the next field start.
// [R10] The system must grant the bus within the overflow latency budget of the capture format.
// [R11] Each FIFO word has a 4-bit tag; the packed and planar tags switch the engine mode.
// [R12] The write instruction has opcode 0001 in bits 31:28, a byte count in bits 11:0 and a target DWORD.
// [R13] Software brackets field programs with sync instructions and closes them with a jump back.
// [R14] After an instruction the next one is fetched from the following address unless a jump redirects.
package vcd_pkg;
   localparam logic [3:0] VCD_OP_WRITE = 4'h1;
   localparam logic [3:0] VCD_OP_SKIP = 4'h2;
   localparam logic [3:0] VCD_OP_JUMP = 4'h7;
   localparam logic [3:0] VCD_OP_SYNC = 4'h8;
   localparam logic [3:0] VCD_OP_PLANAR = 4'h9;
   localparam logic [3:0] VCD_TAG_PACKED = 4'h6;
   localparam logic [3:0] VCD_TAG_PLANAR = 4'hE;
   localparam logic [3:0] VCD_TAG_EVEN_END = 4'h4;
   localparam logic [3:0] VCD_TAG_ODD_END = 4'hC;
   localparam int VCD_OP_HI = 31;
   localparam int VCD_OP_LO = 28;
   localparam int VCD_CNT_HI = 11;
   localparam int VCD_SYNC_TAG_HI = 3;
   localparam logic [31:0] VCD_ADDR_STEP = 32'h0000_0004;
   localparam logic [11:0] VCD_BYTES_PER_WORD = 12'h004;
   localparam int VCD_LAT_NTSC640_US = 41;
   localparam int VCD_LAT_NTSC320_US = 83;
   localparam int VCD_LAT_PAL768_US = 34;

   typedef struct packed {
      logic [3:0] tag;
      logic [31:0] data;
   } vcd_fifo_word_t;

   typedef struct packed {
      logic write;
      logic [31:0] addr;
      logic [31:0] data;
   } vcd_bm_req_t;

   typedef enum logic [1:0] {VCD_MODE_PACKED, VCD_MODE_PLANAR} vcd_mode_t;
endpackage : vcd_pkg

// [hdl/vcd_risc_dma.sv]
// RISC-programmed DMA engine moving capture FIFO words to the bus-master port.
`timescale 1ns/100ps
module vcd_risc_dma
   import vcd_pkg::*;
#(
   parameter bit PLANAR_EN = 1'b1
)
(
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic [31:0] start_addr_i,
   input wire logic start_i,
   input wire logic stop_i,
   input wire vcd_fifo_word_t fifo_word_i,
   input wire logic fifo_valid_i,
   input wire logic fifo_overflow_i,
   output logic fifo_read_o,
   output vcd_bm_req_t bm_req_o,
   output logic bm_valid_o,
   input wire logic bm_ready_i,
   input wire logic [31:0] bm_rdata_i,
   output logic running_o,
   output logic planar_mode_o,
   output logic overflow_o,
   output logic bad_op_o
);

   // ****************************************************************
   // State
   // ****************************************************************
   typedef enum logic [2:0] {S_IDLE, S_FETCH0, S_FETCH1, S_EXEC, S_MOVE, S_SYNC, S_DRAIN} vcd_state_t;

   vcd_state_t state_reg;
   vcd_state_t state_next;
   logic [31:0] pc_reg;
   logic [31:0] ins_reg;
   logic [31:0] arg_reg;
   logic [31:0] dst_reg;
   logic [11:0] cnt_reg;
   logic planar_reg;
   logic ovf_reg;
   logic bad_reg;

   // ****************************************************************
   // Parameter checks
   // ****************************************************************
   // The byte count field must sit below the opcode field of the first DWORD.
   if (VCD_CNT_HI >= VCD_OP_LO)
   begin : g_field_check
      $error("Byte count field overlaps the opcode field.");
   end

   // ****************************************************************
   // Functions
   // ****************************************************************
   // Counts down by one DWORD and stops at zero, so an odd count cannot wrap.
   function automatic logic [11:0] dec_count(input logic [11:0] c);
      dec_count = (c > VCD_BYTES_PER_WORD) ? c - VCD_BYTES_PER_WORD : 12'h000;
   endfunction : dec_count

   // Planar opcodes are not served here and count as unknown.
   function automatic logic op_known(input logic [3:0] op);
      op_known = (op == VCD_OP_WRITE) || (op == VCD_OP_SKIP) || (op == VCD_OP_SYNC) || (op == VCD_OP_JUMP);
   endfunction : op_known

   // ****************************************************************
   // Decode
   // ****************************************************************
   wire [3:0] opcode = ins_reg[VCD_OP_HI:VCD_OP_LO];
   wire [3:0] sync_tag = ins_reg[VCD_SYNC_TAG_HI:0];
   wire in_idle = (state_reg == S_IDLE);
   wire in_exec = (state_reg == S_EXEC);
   wire fetching = (state_reg == S_FETCH0) || (state_reg == S_FETCH1);
   wire fetch_done = fetching && bm_ready_i;
   wire moving = (state_reg == S_MOVE) && (cnt_reg != 12'h000);
   wire skip_op = (opcode == VCD_OP_SKIP);
   wire word_go = moving && fifo_valid_i && bm_ready_i;
   wire skip_go = moving && fifo_valid_i;
   wire move_step = skip_op ? skip_go : word_go;
   wire load_start = in_idle && start_i;
   wire ovf_hit = fifo_overflow_i && !in_idle;
   wire known_op = op_known(opcode);
   wire mode_tag = (fifo_word_i.tag == VCD_TAG_PACKED) || (PLANAR_EN && fifo_word_i.tag == VCD_TAG_PLANAR); // [R11]
   wire tag_hit = fifo_valid_i && (fifo_word_i.tag == sync_tag);
   wire drain_pop = (state_reg == S_DRAIN) && fifo_valid_i;
   wire sync_pop = (state_reg == S_SYNC) && fifo_valid_i;
   wire pop = move_step || sync_pop || drain_pop;

   // ****************************************************************
   // Bus-master and FIFO handshakes
   // ****************************************************************
   assign bm_valid_o = fetching || (moving && fifo_valid_i && !skip_op); // [R6] [R8]
   assign bm_req_o.write = !fetching;
   assign bm_req_o.addr = fetching ? pc_reg : dst_reg;
   // Fetch requests carry no data, so a moving FIFO head cannot disturb a held fetch.
   assign bm_req_o.data = fetching ? 32'h0000_0000 : fifo_word_i.data;
   assign fifo_read_o = pop; // [R9]
   assign running_o = !in_idle;
   assign planar_mode_o = planar_reg;
   assign overflow_o = ovf_reg;
   assign bad_op_o = bad_reg;

   // ****************************************************************
   // Sequencer
   // ****************************************************************
   always_comb
   begin
      state_next = state_reg;
      unique case (state_reg)
         S_IDLE: if (start_i) state_next = S_FETCH0; // [R5] [R6]
         S_FETCH0: if (bm_ready_i) state_next = S_FETCH1; // [R1]
         S_FETCH1: if (bm_ready_i) state_next = S_EXEC;
         S_EXEC:
         begin
            unique case (opcode) // [R7]
               VCD_OP_WRITE, VCD_OP_SKIP: state_next = S_MOVE; // [R12]
               VCD_OP_SYNC: state_next = S_SYNC;
               VCD_OP_JUMP: state_next = S_FETCH0;
               default: state_next = S_IDLE; // [R2]
            endcase
         end
         S_MOVE: if (!moving) state_next = S_FETCH0; // [R14]
         S_SYNC: if (tag_hit) state_next = S_FETCH0;
         S_DRAIN: if (fifo_valid_i && mode_tag) state_next = S_SYNC;
         default: state_next = S_IDLE;
      endcase
      if (ovf_hit)
         state_next = S_DRAIN; // [R9]
      if (stop_i)
         state_next = S_IDLE;
   end

   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i)
         state_reg <= S_IDLE;
      else
         state_reg <= state_next;
   end

   // ****************************************************************
   // Program counter and instruction registers
   // ****************************************************************
   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i)
         pc_reg <= '0;
      else if (load_start)
         pc_reg <= start_addr_i; // [R5]
      else if (in_exec && opcode == VCD_OP_JUMP)
         pc_reg <= arg_reg; // [R14]
      else if (fetch_done)
         pc_reg <= pc_reg + VCD_ADDR_STEP; // [R14]
   end

   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i)
         ins_reg <= '0;
      else if (state_reg == S_FETCH0 && bm_ready_i)
         ins_reg <= bm_rdata_i;
   end

   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i)
         arg_reg <= '0;
      else if (state_reg == S_FETCH1 && bm_ready_i)
         arg_reg <= bm_rdata_i;
   end

   // ****************************************************************
   // Transfer address and byte count
   // ****************************************************************
   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i)
         dst_reg <= '0;
      else if (in_exec)
         dst_reg <= arg_reg; // [R3] [R4]
      else if (move_step)
         dst_reg <= dst_reg + VCD_ADDR_STEP;
   end

   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i)
         cnt_reg <= '0;
      else if (in_exec)
         cnt_reg <= ins_reg[VCD_CNT_HI:0];
      else if (move_step)
         cnt_reg <= dec_count(cnt_reg);
   end

   // ****************************************************************
   // Status flags
   // ****************************************************************
   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i)
         planar_reg <= 1'b0;
      else if (pop && mode_tag)
         planar_reg <= (fifo_word_i.tag == VCD_TAG_PLANAR); // [R11]
   end

   // An overflow is only taken while running, so a start always clears the flag.
   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i)
         ovf_reg <= 1'b0;
      else if (ovf_hit)
         ovf_reg <= 1'b1; // [R9]
      else if (load_start)
         ovf_reg <= 1'b0;
   end

   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i)
         bad_reg <= 1'b0;
      else if (in_exec && !known_op)
         bad_reg <= 1'b1; // [R2]
      else if (load_start)
         bad_reg <= 1'b0;
   end

endmodule : vcd_risc_dma

// [test/vcd_risc_dma_assertions.sv]
// Port timing checker for the RISC DMA engine.
`timescale 1ns/100ps
module vcd_risc_dma_assertions
   import vcd_pkg::*;
(
   input wire logic clk_i, sys_rst_i, start_i, stop_i, fifo_valid_i, fifo_overflow_i, bm_ready_i,
   input wire logic [31:0] start_addr_i, bm_rdata_i,
   input wire vcd_fifo_word_t fifo_word_i,
   input wire logic fifo_read_o, bm_valid_o, running_o, planar_mode_o, overflow_o, bad_op_o,
   input wire vcd_bm_req_t bm_req_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);
   sequence s_fetch_done;
      bm_valid_o && !bm_req_o.write && bm_ready_i;
   endsequence
   sequence s_word_done;
      bm_valid_o && bm_req_o.write && bm_ready_i;
   endsequence
   a_idle_quiet: assert property (!running_o |-> !bm_valid_o)
      else $error("request while idle");
   a_start_fetch: assert property (start_i && !running_o |=> bm_valid_o && !bm_req_o.write
      && bm_req_o.addr == $past(start_addr_i)) else $error("no first fetch");
   a_req_held: assert property (bm_valid_o && !bm_ready_i && !stop_i && !fifo_overflow_i
      |=> bm_valid_o && $stable(bm_req_o))
      else $error("request dropped");
   a_fetch_next: assert property (s_fetch_done ##1 bm_valid_o && !bm_req_o.write
      |-> bm_req_o.addr == $past(bm_req_o.addr) + VCD_ADDR_STEP) else $error("fetch address step");
   a_word_next: assert property (s_word_done ##1 bm_valid_o && bm_req_o.write
      |-> bm_req_o.addr == $past(bm_req_o.addr) + VCD_ADDR_STEP) else $error("write address step");
   a_word_pop: assert property (s_word_done |-> fifo_read_o && bm_req_o.data == fifo_word_i.data)
      else $error("write data or pop");
   a_pop_present: assert property (fifo_read_o |-> fifo_valid_i)
      else $error("pop of empty FIFO");
   a_bad_halt: assert property (bad_op_o |-> !running_o)
      else $error("running after bad opcode");
   a_ovf_flag: assert property (fifo_overflow_i && running_o |=> overflow_o)
      else $error("overflow not flagged");
endmodule : vcd_risc_dma_assertions
bind vcd_risc_dma vcd_risc_dma_assertions u_chk (.*);

// [test/vcd_host_mem.sv]
// Host memory model behind the bus-master port.
`timescale 1ns/100ps
module vcd_host_mem
   import vcd_pkg::*;
(
   input wire logic clk_i,
   input wire logic slow_i,
   input wire vcd_bm_req_t req_i,
   input wire logic valid_i,
   output logic ready_o,
   output logic [31:0] rdata_o
);
   logic [31:0] mem [0:63];
   logic pace_reg = 1'b0;
   wire [31:0] word_w = mem[req_i.addr[7:2]];
   // A slow host grants every other cycle, well inside the latency budget.
   assign ready_o = valid_i && (!slow_i || pace_reg);
   assign rdata_o = ready_o ? word_w : ~word_w;
   always @(posedge clk_i)
   begin
      pace_reg <= !pace_reg;
      if (ready_o && req_i.write)
         mem[req_i.addr[7:2]] <= req_i.data;
   end
endmodule : vcd_host_mem

// [test/video_capture_risc_dma_tb_top.sv]
// Self-checking bench for the RISC DMA engine.
`timescale 1ns/100ps
module video_capture_risc_dma_tb_top
   import vcd_pkg::*;
;
   logic clk_i = 1'b0, sys_rst_i = 1'b1, start_i = 1'b0, stop_i = 1'b0, fifo_valid_i = 1'b0;
   logic fifo_overflow_i = 1'b0, slow = 1'b1, fifo_read_o, bm_valid_o, bm_ready_i, running_o;
   logic planar_mode_o, overflow_o, bad_op_o;
   logic [31:0] start_addr_i = 32'h0, bm_rdata_i;
   vcd_fifo_word_t fifo_word_i = '0;
   vcd_bm_req_t bm_req_o;
   int errors = 0, checked = 0;
   typedef struct {vcd_fifo_word_t word; int idx;} vcd_row_t;
   vcd_row_t rows [5] = '{'{'{4'h6, 32'h0}, 0}, '{'{4'h0, 32'h1111}, 32}, '{'{4'h0, 32'h2222}, 33},
      '{'{4'h0, 32'h3333}, 0}, '{'{4'h0, 32'h4444}, 40}};
   logic [31:0] prog [10] = '{32'h80000006, 32'h0, 32'h10000008, 32'h80, 32'h20000004, 32'h0,
      32'h10000004, 32'hA0, 32'h70000000, 32'h40};
   vcd_risc_dma dut (
      .clk_i(clk_i),
      .sys_rst_i(sys_rst_i),
      .start_addr_i(start_addr_i),
      .start_i(start_i),
      .stop_i(stop_i),
      .fifo_word_i(fifo_word_i),
      .fifo_valid_i(fifo_valid_i),
      .fifo_overflow_i(fifo_overflow_i),
      .fifo_read_o(fifo_read_o),
      .bm_req_o(bm_req_o),
      .bm_valid_o(bm_valid_o),
      .bm_ready_i(bm_ready_i),
      .bm_rdata_i(bm_rdata_i),
      .running_o(running_o),
      .planar_mode_o(planar_mode_o),
      .overflow_o(overflow_o),
      .bad_op_o(bad_op_o)
   );
   vcd_host_mem m (.clk_i, .slow_i(slow), .req_i(bm_req_o), .valid_i(bm_valid_o), .ready_o(bm_ready_i),
      .rdata_o(bm_rdata_i));
   task automatic chk(logic [31:0] got, logic [31:0] exp);
      checked++;
      if (got !== exp)
      begin
         errors++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic stop_test();
      $display("errors=%0d checked=%0d", errors, checked);
      if (errors == 0 && checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : stop_test
   initial forever #5 clk_i = ~clk_i;
   initial
   begin
      #50us;
      errors++;
      stop_test();
   end
   initial
   begin
      foreach (m.mem[i]) m.mem[i] = (i < 10) ? prog[i] : 32'h0;
      m.mem[16] = 32'hF0000000;
      repeat (6) @(posedge clk_i);
      sys_rst_i <= 1'b0;
      start_i <= 1'b1;
      @(posedge clk_i);
      start_i <= 1'b0;
      foreach (rows[i])
      begin
         fifo_word_i <= rows[i].word;
         fifo_valid_i <= 1'b1;
         do @(posedge clk_i); while (fifo_read_o !== 1'b1);
      end
      fifo_valid_i <= 1'b0;
      for (int i = 0; i < 40 && bad_op_o !== 1'b1; i++) @(posedge clk_i);
      chk(bad_op_o, 1);
      chk(running_o, 0);
      chk(planar_mode_o, 0);
      foreach (rows[i]) if (rows[i].idx != 0) chk(m.mem[rows[i].idx], rows[i].word.data);
      chk(m.mem[34], 0);
      sys_rst_i <= 1'b1;
      @(posedge clk_i);
      sys_rst_i <= 1'b0;
      slow <= 1'b0;
      @(posedge clk_i);
      chk(bad_op_o, 0);
      chk(overflow_o, 0);
      start_i <= 1'b1;
      @(posedge clk_i);
      start_i <= 1'b0;
      fifo_overflow_i <= 1'b1;
      @(posedge clk_i);
      fifo_overflow_i <= 1'b0;
      @(posedge clk_i);
      chk(overflow_o, 1);
      fifo_word_i <= '{VCD_TAG_PLANAR, 32'h0};
      fifo_valid_i <= 1'b1;
      @(posedge clk_i);
      fifo_valid_i <= 1'b0;
      @(posedge clk_i);
      chk(planar_mode_o, 1);
      stop_i <= 1'b1;
      @(posedge clk_i);
      stop_i <= 1'b0;
      @(posedge clk_i);
      chk(running_o, 0);
      stop_test();
   end
endmodule : video_capture_risc_dma_tb_top
